// ===== hw/flc_regs.sv
/*
  Control logic of a flash LED driver: two write-only control registers,
  sink current decode, safety timeout, sleep and fault gating.
  Assumes register writes arrive already deframed from the single wire
  receiver on the core clock; pins and analog comparator flags are async.
*/
// Overview of operation
// - sink off means sleep, oscillator and pump off
// - regulators stay usable during sleep
// - overvoltage flag holds pump enable off
// - overheat disables outputs, registers kept
// - reduced pump limit below low, leaves above high
// - open sink output disables the sink
// - sink control at 0x02 resets 0x10
// - regulator control at 0x03 resets 0x00
// - timeout enable turns sink off after 1s
// - after timeout, trigger low or code written to zero
// - low range codes map 50 to 250 mA
// - high range codes map 300 to 400 mA
// - pin low 10 ms shuts down, defaults restored
// - trigger pin high activates the sink
// - writes carry 5-bit address, 8 data bits
module flc_regs #(
  parameter int TIMEOUT_COUNT = flc_pkg::TIMEOUT_CYCLES,
  parameter int DISABLE_COUNT = flc_pkg::DISABLE_CYCLES,
  parameter int ENABLE_COUNT = flc_pkg::ENABLE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_write_strobe,
  input wire logic [flc_pkg::ADDR_W-1:0] i_write_addr,
  input wire logic [flc_pkg::DATA_W-1:0] i_write_data,
  input wire logic i_single_wire_pin,
  input wire logic i_trigger_pin,
  input wire logic i_overvoltage_guard,
  input wire logic i_overheat_guard,
  input wire logic i_pump_output_below_low,
  input wire logic i_pump_output_above_high,
  input wire logic i_sink_open,
  output logic o_sink_enable,
  output logic [3:0] o_sink_level,
  output logic o_pump_enable,
  output logic o_osc_enable,
  output logic o_sleep,
  output logic o_reduced_limit,
  output logic [3:0] o_regulator_one_code,
  output logic [2:0] o_regulator_two_code,
  output logic o_timeout_flag,
  output logic o_shutdown
);
  import flc_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  logic swp_s, trig_s, ovp_s, ot_s, below_s, above_s, open_s;

  // two flops per async input, only stage b is read
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= {i_single_wire_pin, i_trigger_pin, i_overvoltage_guard, i_overheat_guard,
                 i_pump_output_below_low, i_pump_output_above_high, i_sink_open};
      sync_b <= sync_a;
    end
  end
  assign {swp_s, trig_s, ovp_s, ot_s, below_s, above_s, open_s} = sync_b;

  // ----------------------------------------------------------------
  // current decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] flc_level(input logic [2:0] code, input logic hi_range);
    logic [3:0] lvl;
    lvl = 4'h0;
    if (code != 3'h0) begin
      if (!hi_range) begin
        lvl = ({1'b0, code} > LEVEL_SPOT_MAX) ? LEVEL_SPOT_MAX : {1'b0, code};
      end else begin
        lvl = (code >= 3'h3) ? LEVEL_FLASH_MAX : LEVEL_FLASH_BASE + {1'b0, code};
      end
    end
    return lvl;
  endfunction : flc_level

  // ----------------------------------------------------------------
  // main state
  // ----------------------------------------------------------------
  logic [7:0] sink_control, next_sink_control;
  logic [7:0] regulator_control, next_regulator_control;
  logic [COUNT_W-1:0] timer, next_timer;
  logic [COUNT_W-1:0] pin_count, next_pin_count;
  logic next_shutdown, next_timeout_flag, next_reduced_limit;
  logic next_sink_enable, next_pump_enable;
  logic [3:0] next_sink_level, next_reg_one;
  logic [2:0] next_reg_two;
  logic wr_sink, wr_reg, sink_request;

  // next values of registers, counters and outputs
  always_comb begin
    next_sink_control = sink_control;
    next_regulator_control = regulator_control;
    next_shutdown = o_shutdown;
    next_pin_count = pin_count;
    next_timeout_flag = o_timeout_flag;
    next_timer = timer;
    next_reduced_limit = o_reduced_limit;
    wr_sink = 1'b0;
    wr_reg = 1'b0;
    // pin low long enough shuts down, high long enough wakes up
    if (swp_s == o_shutdown) begin
      next_pin_count = pin_count + COUNT_W'(1);
      if (o_shutdown && pin_count >= COUNT_W'(ENABLE_COUNT - 1)) begin
        next_shutdown = 1'b0;
        next_pin_count = '0;
      end else if (!o_shutdown && pin_count >= COUNT_W'(DISABLE_COUNT - 1)) begin
        next_shutdown = 1'b1;
        next_pin_count = '0;
      end
    end else begin
      next_pin_count = '0;
    end
    // writes are held off in shutdown and thermal shutdown
    if (i_write_strobe && !o_shutdown && !ot_s) begin
      wr_sink = (i_write_addr == SINK_CONTROL_ADDR);
      wr_reg = (i_write_addr == REGULATOR_CONTROL_ADDR);
    end
    if (wr_sink) begin
      next_sink_control = i_write_data & SINK_CONTROL_MASK;
    end
    if (wr_reg) begin
      next_regulator_control = i_write_data & REGULATOR_CONTROL_MASK;
    end
    if (o_shutdown) begin
      next_sink_control = SINK_CONTROL_RESET;
      next_regulator_control = REGULATOR_CONTROL_RESET;
    end
    // timeout latch clears on trigger low or code written to zero
    if (!trig_s || (wr_sink && i_write_data[SINK_CODE_MSB:SINK_CODE_LSB] == 3'h0)) begin
      next_timeout_flag = 1'b0;
    end
    // active-time counter, set wins over clear
    if (o_sink_enable) begin
      next_timer = timer + COUNT_W'(1);
      if (sink_control[TIMEOUT_ENABLE_BIT] && timer >= COUNT_W'(TIMEOUT_COUNT - 1)) begin
        next_timeout_flag = 1'b1;
        next_timer = '0;
      end
    end else begin
      next_timer = '0;
    end
    if (o_shutdown) begin
      next_timeout_flag = 1'b0;
    end
    // pump current limit hysteresis
    if (below_s) begin
      next_reduced_limit = 1'b1;
    end else if (above_s) begin
      next_reduced_limit = 1'b0;
    end
    // sink, pump and regulator gating
    sink_request = (next_sink_control[SINK_CODE_MSB:SINK_CODE_LSB] != 3'h0) && trig_s;
    next_sink_enable = sink_request && !next_timeout_flag && !next_shutdown
                       && !ot_s && !open_s;
    next_sink_level = next_sink_enable ?
      flc_level(next_sink_control[SINK_CODE_MSB:SINK_CODE_LSB],
                next_sink_control[RANGE_SELECT_BIT]) : 4'h0;
    next_pump_enable = next_sink_enable && !ovp_s;
    next_reg_one = (ot_s || next_shutdown) ? 4'h0 :
      next_regulator_control[REG_ONE_MSB:REG_ONE_LSB];
    next_reg_two = (ot_s || next_shutdown) ? 3'h0 :
      next_regulator_control[REG_TWO_MSB:REG_TWO_LSB];
  end

  // register the state and every output
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sink_control <= SINK_CONTROL_RESET;
      regulator_control <= REGULATOR_CONTROL_RESET;
      timer <= '0;
      pin_count <= '0;
      o_shutdown <= 1'b1;
      o_timeout_flag <= 1'b0;
      o_reduced_limit <= 1'b0;
      o_sink_enable <= 1'b0;
      o_sink_level <= 4'h0;
      o_pump_enable <= 1'b0;
      o_osc_enable <= 1'b0;
      o_sleep <= 1'b1;
      o_regulator_one_code <= 4'h0;
      o_regulator_two_code <= 3'h0;
    end else begin
      sink_control <= next_sink_control;
      regulator_control <= next_regulator_control;
      timer <= next_timer;
      pin_count <= next_pin_count;
      o_shutdown <= next_shutdown;
      o_timeout_flag <= next_timeout_flag;
      o_reduced_limit <= next_reduced_limit;
      o_sink_enable <= next_sink_enable;
      o_sink_level <= next_sink_level;
      o_pump_enable <= next_pump_enable;
      o_osc_enable <= next_sink_enable;
      o_sleep <= !next_sink_enable;
      o_regulator_one_code <= next_reg_one;
      o_regulator_two_code <= next_reg_two;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  sleep_osc_off_a: assert property (o_sleep |-> !o_osc_enable && !o_pump_enable)
    else $error("sleep with oscillator or pump running");
  reg_in_sleep_a: assert property (o_sleep && !ot_s && !next_shutdown
      && next_regulator_control[REG_ONE_MSB:REG_ONE_LSB] != 4'h0
      |=> o_regulator_one_code != 4'h0)
    else $error("regulator one off while enabled");
  ovp_pump_off_a: assert property (ovp_s |=> !o_pump_enable)
    else $error("pump enabled during overvoltage");
  ot_outputs_off_a: assert property (ot_s |=> !o_sink_enable && o_regulator_one_code == 4'h0
      && o_regulator_two_code == 3'h0)
    else $error("outputs active in thermal shutdown");
  ot_regs_kept_a: assert property (ot_s && !o_shutdown |=> $stable(sink_control)
      && $stable(regulator_control))
    else $error("register changed in thermal shutdown");
  limit_hyst_a: assert property (o_reduced_limit && !above_s |=> o_reduced_limit)
    else $error("reduced limit left early");
  open_sink_off_a: assert property (open_s |=> !o_sink_enable)
    else $error("sink on with open output");
  shutdown_defaults_a: assert property (o_shutdown |=> sink_control == SINK_CONTROL_RESET
      && regulator_control == REGULATOR_CONTROL_RESET)
    else $error("defaults not restored in shutdown");
  timeout_off_a: assert property (o_timeout_flag |-> !o_sink_enable)
    else $error("sink on after timeout");
  range_map_a: assert property (o_sink_enable && sink_control[RANGE_SELECT_BIT]
      |-> o_sink_level > LEVEL_SPOT_MAX)
    else $error("high range level too low");
  spot_map_a: assert property (o_sink_enable && !sink_control[RANGE_SELECT_BIT]
      |-> o_sink_level != 4'h0 && o_sink_level <= LEVEL_SPOT_MAX)
    else $error("low range level out of span");

  sink_on_c: cover property (o_sink_enable && o_sink_level == LEVEL_FLASH_MAX);
  timeout_c: cover property ($rose(o_timeout_flag));
  shutdown_c: cover property ($rose(o_shutdown));
endmodule : flc_regs

// ===== shared/flc_pkg.sv
/*
  Constants for the flash LED control register bank: register addresses,
  field positions, reset values and timing counts.
  Assumes a 10 MHz core clock.
*/
package flc_pkg;
  // ----------------------------------------------------------------
  // bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] SINK_CONTROL_ADDR = 5'h02;
  localparam logic [4:0] REGULATOR_CONTROL_ADDR = 5'h03;
  localparam logic [7:0] SINK_CONTROL_RESET = 8'h10;
  localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SINK_CONTROL_MASK = 8'h1f;
  localparam logic [7:0] REGULATOR_CONTROL_MASK = 8'h7f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RANGE_SELECT_BIT = 0;
  localparam int SINK_CODE_LSB = 1;
  localparam int SINK_CODE_MSB = 3;
  localparam int TIMEOUT_ENABLE_BIT = 4;
  localparam int REG_ONE_LSB = 0;
  localparam int REG_ONE_MSB = 3;
  localparam int REG_TWO_LSB = 4;
  localparam int REG_TWO_MSB = 6;

  // ----------------------------------------------------------------
  // sink levels in 50 mA steps
  // ----------------------------------------------------------------
  localparam logic [3:0] LEVEL_SPOT_MAX = 4'h5;
  localparam logic [3:0] LEVEL_FLASH_MAX = 4'h8;
  localparam logic [3:0] LEVEL_FLASH_BASE = 4'h5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 10_000_000;
  localparam int TIMEOUT_MS = 1000;
  localparam int DISABLE_MS = 10;
  localparam int ENABLE_MS = 1;
  localparam int TIMEOUT_CYCLES = CLOCK_HZ / 1000 * TIMEOUT_MS;
  localparam int DISABLE_CYCLES = CLOCK_HZ / 1000 * DISABLE_MS;
  localparam int ENABLE_CYCLES = CLOCK_HZ / 1000 * ENABLE_MS;
  localparam int COUNT_W = 24;
endpackage : flc_pkg

// ===== sim/flc_host.sv
/*
  Host model: drives deframed register writes and the single wire pin.
  Assumes the bench clock; all outputs change on its falling edge.
*/
module flc_host (
  input wire logic i_clock,
  output logic o_write_strobe,
  output logic [flc_pkg::ADDR_W-1:0] o_write_addr,
  output logic [flc_pkg::DATA_W-1:0] o_write_data,
  output logic o_single_wire_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import flc_pkg::*;

  // idle bus, pin high so the device can wake
  initial begin
    o_write_strobe = 1'b0;
    o_write_addr = 5'h00;
    o_write_data = 8'h00;
    o_single_wire_pin = 1'b1;
  end

  // one write: address and data in one strobe
  task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
    @(negedge i_clock);
    o_write_strobe = 1'b1;
    o_write_addr = addr;
    o_write_data = data & ((addr == SINK_CONTROL_ADDR) ? SINK_CONTROL_MASK
      : REGULATOR_CONTROL_MASK);
    @(negedge i_clock);
    o_write_strobe = 1'b0;
    o_write_addr = ~addr;
    o_write_data = ~o_write_data; // no stale value on an idle bus
  endtask : write_reg

  // pin level, held low long to shut down
  task automatic set_pin(input logic v);
    @(negedge i_clock);
    o_single_wire_pin = v;
  endtask : set_pin
endmodule : flc_host

// ===== sim/flc_regs_tb.sv
/*
  Self-checking bench of the flash LED control registers.
  Assumes the host model and short count parameters.
*/
module flc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flc_pkg::*;
  localparam int TO_N = 50;
  localparam int DIS_N = 20;
  localparam int EN_N = 5;
  logic i_clock, i_resetn, i_write_strobe, i_single_wire_pin, i_trigger_pin, i_sink_open;
  logic i_overvoltage_guard, i_overheat_guard, i_pump_output_below_low, i_pump_output_above_high;
  logic [4:0] i_write_addr;
  logic [7:0] i_write_data, rv;
  logic o_sink_enable, o_pump_enable, o_osc_enable, o_sleep, o_reduced_limit, o_timeout_flag;
  logic o_shutdown;
  logic [3:0] o_sink_level, o_regulator_one_code;
  logic [2:0] o_regulator_two_code;
  int error_cnt, n_tests, cycles;
  integer seed;

  flc_host u_host (.i_clock, .o_write_strobe(i_write_strobe), .o_write_addr(i_write_addr),
    .o_write_data(i_write_data), .o_single_wire_pin(i_single_wire_pin));
  flc_regs #(.TIMEOUT_COUNT(TO_N), .DISABLE_COUNT(DIS_N), .ENABLE_COUNT(EN_N)) u_dut (.i_clock,
    .i_resetn, .i_write_strobe, .i_write_addr, .i_write_data, .i_single_wire_pin,
    .i_trigger_pin, .i_overvoltage_guard, .i_overheat_guard, .i_pump_output_below_low,
    .i_pump_output_above_high, .i_sink_open, .o_sink_enable, .o_sink_level, .o_pump_enable,
    .o_osc_enable, .o_sleep, .o_reduced_limit, .o_regulator_one_code, .o_regulator_two_code,
    .o_timeout_flag, .o_shutdown);

  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_sink(input logic en, input logic [3:0] lvl);
    chk({o_sink_enable, o_sink_level}, {3'h0, en, lvl}, "sink");
    chk({o_sleep, o_osc_enable, o_pump_enable}, {5'h00, ~en, en, en}, "sleep osc pump");
  endtask : chk_sink
  task automatic chk_regs(input logic [7:0] exp);
    chk({1'b0, o_regulator_two_code, o_regulator_one_code}, exp, "regulators");
  endtask : chk_regs
  function automatic logic [3:0] exp_level(input logic rng, input logic [2:0] code);
    if (code == 3'h0) return 4'h0;
    if (!rng) return (code > 3'h5) ? 4'h5 : {1'b0, code};
    return (code > 3'h2) ? 4'h8 : {1'b0, code} + 4'h5;
  endfunction : exp_level
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hfa42;
    {error_cnt, n_tests} = '0;
    {i_resetn, i_overvoltage_guard, i_overheat_guard, i_sink_open} = 4'h0;
    {i_pump_output_below_low, i_pump_output_above_high, i_trigger_pin} = 3'h1;
    tick(20);
    chk({o_shutdown, o_sleep}, 8'h03, "reset state");
    i_resetn = 1'b1;
    tick(EN_N + 6);
    chk(o_shutdown, 8'h00, "wake");
    chk_sink(1'b0, 4'h0);
    chk_regs(8'h00);
    end_test("reset");
    // every code in both ranges, timeout off
    for (int i = 0; i < 16; i++) begin
      u_host.write_reg(SINK_CONTROL_ADDR, {4'h0, i[3:1], i[0]});
      tick(1);
      chk_sink(i[3:1] != 3'h0, exp_level(i[0], i[3:1]));
    end
    end_test("levels");
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rv = 8'($random(seed));
      u_host.write_reg(REGULATOR_CONTROL_ADDR, rv);
      u_host.write_reg({1'b1, rv[3:0]}, ~rv);
      tick(1);
      chk_regs(rv & 8'h7f);
      chk_sink(1'b0, 4'h0);
    end
    end_test("regulators");
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h06);
    i_overvoltage_guard = 1'b1;
    tick(4);
    chk({o_sink_enable, o_pump_enable}, 8'h02, "pump held");
    i_overvoltage_guard = 1'b0;
    i_pump_output_below_low = 1'b1;
    tick(4);
    chk({o_pump_enable, o_reduced_limit}, 8'h03, "pump back, limit");
    i_pump_output_below_low = 1'b0;
    tick(4);
    chk(o_reduced_limit, 8'h01, "limit kept");
    i_pump_output_above_high = 1'b1;
    i_sink_open = 1'b1;
    tick(4);
    chk(o_reduced_limit, 8'h00, "limit left");
    chk_sink(1'b0, 4'h0);
    i_sink_open = 1'b0;
    i_overheat_guard = 1'b1;
    tick(4);
    chk_sink(1'b0, 4'h0);
    chk_regs(8'h00);
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h0a);
    i_overheat_guard = 1'b0;
    tick(4);
    chk_sink(1'b1, 4'h3);
    chk_regs(rv & 8'h7f);
    end_test("faults");
    // sink off first so the active-time counter starts from zero
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h10);
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h14);
    tick(TO_N - 2);
    chk_sink(1'b1, 4'h2);
    tick(5);
    chk({o_timeout_flag, o_sink_enable}, 8'h02, "timeout");
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h14);
    tick(1);
    chk_sink(1'b0, 4'h0);
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h10);
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h14);
    tick(1);
    chk({o_timeout_flag, o_sink_enable}, 8'h01, "rearm by code");
    tick(TO_N + 3);
    i_trigger_pin = 1'b0;
    tick(4);
    chk({o_timeout_flag, o_sink_enable}, 8'h00, "rearm by pin");
    i_trigger_pin = 1'b1;
    u_host.write_reg(SINK_CONTROL_ADDR, 8'h04);
    tick(TO_N + 3);
    chk_sink(1'b1, 4'h2);
    end_test("timeout");
    u_host.set_pin(1'b0);
    tick(DIS_N - 4);
    u_host.set_pin(1'b1);
    tick(2);
    chk(o_shutdown, 8'h00, "blip restarts");
    u_host.set_pin(1'b0);
    tick(DIS_N + 6);
    chk(o_shutdown, 8'h01, "shutdown");
    chk_sink(1'b0, 4'h0);
    u_host.set_pin(1'b1);
    tick(EN_N + 6);
    chk(o_shutdown, 8'h00, "rewake");
    chk_regs(8'h00);
    end_test("shutdown");
    print_verdict();
  end
endmodule : flc_regs_tb
